/* File: hdl/mts_pkg.sv */
// constants and types of the multichannel trigger sequencer
package mts_pkg;
    // --------------------------------------------------
    // timing
    // --------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC_DEF = MS_NS / CLK_NS;
    localparam int SLOT_US = 200;
    localparam int SLOT_CYC_DEF = (SLOT_US * 1000) / CLK_NS;
    localparam int LAT_US = 1;
    localparam int LAT_CYC = (LAT_US * 1000) / CLK_NS;
    localparam int HOLD_MS = 10;
    localparam logic [15:0] PER_DEF = 16'h03e8;
    localparam logic [15:0] CNT_DEF = 16'h0001;
    // --------------------------------------------------
    // register map
    // --------------------------------------------------
    localparam int AW = 8;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_COUNT = 8'h04;
    localparam logic [7:0] A_PERIOD = 8'h08;
    localparam logic [7:0] A_TRIG = 8'h0c;
    localparam logic [7:0] A_CFG0 = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h20;
    localparam logic [7:0] A_ERR = 8'h24;
    localparam int CFG_CAL = 0;
    localparam int CFG_SCALE = 2;
    localparam int CFG_ATT = 4;
    localparam int ERR_PER = 0;
    localparam int ERR_MODE = 1;
    // arbitrary code value
    localparam logic [7:0] BAD_MODE_ERROR_CODE = 8'h01;
    // --------------------------------------------------
    // encodings
    // --------------------------------------------------
    typedef enum logic [1:0] {
        SRC_LOCAL = 2'b00,
        SRC_EXT = 2'b01,
        SRC_REM = 2'b10
    } mts_src_type;
    localparam logic [1:0] CAL_NONE = 2'h0;
    localparam logic [1:0] CAL_GND = 2'h1;
    localparam logic [1:0] CAL_REFERENCE_THEN_GROUND = 2'h2;
    localparam logic [1:0] CAL_REFERENCE_LATE_GROUND = 2'h3;
    localparam logic [1:0] RD_INPUT = 2'h0;
    localparam logic [1:0] RD_GROUND = 2'h1;
    localparam logic [1:0] RD_REF = 2'h2;
    localparam logic [1:0] ATT_OFF = 2'h0;
    localparam logic [1:0] ATT_ON = 2'h1;
    localparam logic [1:0] SCALE_20V = 2'h0;
endpackage

/* File: hdl/mts_sequencer.sv */
// trigger sequencer for a four-channel voltmeter
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - power-up in local continuous triggering
// - low external input in local selects external
// - external falling edge starts sequences when idle
// - aligned input reading after fixed latency
// - short sequences padded, padding results discarded
// - each channel publishes at own sequence end
// - busy high from trigger to longest end
// - one- to four-slot reading order per calibration mode
// - sequences per trigger programmable, default one
// - too short period flags error, restores 1000ms
// - busy spans whole ensemble including gaps
// - one trigger buffered while busy, rest dropped
// - buffered trigger: busy low 10ms, then start
// - started sequences always complete
// - first external trigger in local is buffered
// - leave external only by source command
// - off local, dashes while settling; next reading new settings
// - remote mode triggers on trigger command
// - wrong-kind triggers ignored in each mode
// - external/remote switch needs one old trigger
// - non-local legal scale/attenuator/calibration combos
// - busy held high in local mode
// - illegal mode forces attenuator on, flags error
module mts_sequencer #(
    parameter int MS_CYC = mts_pkg::MS_CYC_DEF,
    parameter int SLOT_CYC = mts_pkg::SLOT_CYC_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [mts_pkg::AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // trigger pins
    input wire logic i_ext_trig_n,
    output logic o_busy,
    // converter side
    output logic o_read_start,
    output logic [7:0] o_read_kind,
    output logic [3:0] o_pad,
    output logic [3:0] o_publish,
    output logic [3:0] o_dash
);
    import mts_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LAT = 3'b001,
        ST_SLOT = 3'b010,
        ST_GAP = 3'b011,
        ST_HOLD = 3'b100
    } mts_state_type;

    // --------------------------------------------------
    // decoding functions
    // --------------------------------------------------
    function automatic logic [2:0] seq_len(input logic [1:0] cal);
        seq_len = {1'b0, cal} + 3'h1;
    endfunction

    function automatic logic [1:0] slot_kind(input logic [1:0] cal,
                                             input logic [1:0] s);
        slot_kind = RD_INPUT;
        unique case (cal)
            CAL_NONE: slot_kind = RD_INPUT;
            CAL_GND: begin
                if (s == 2'h1) slot_kind = RD_GROUND;
            end
            CAL_REFERENCE_THEN_GROUND: begin
                if (s == 2'h1) slot_kind = RD_REF;
                if (s == 2'h2) slot_kind = RD_GROUND;
            end
            CAL_REFERENCE_LATE_GROUND: begin
                if (s == 2'h1) slot_kind = RD_REF;
                if (s == 2'h3) slot_kind = RD_GROUND;
            end
        endcase
    endfunction

    function automatic logic cfg_legal(input logic [5:0] c);
        logic [1:0] att;
        att = c[CFG_ATT+:2];
        cfg_legal = (att == ATT_ON) ||
            ((c[CFG_SCALE+:2] != SCALE_20V) &&
             (c[CFG_CAL+:2] <= CAL_GND));
    endfunction

    // --------------------------------------------------
    // state
    // --------------------------------------------------
    mts_state_type st_r;
    mts_src_type src_r;
    mts_src_type pmode_r;
    logic pend_r;
    logic buf_r;
    logic ext_m_r, ext_s_r, ext_d_r;
    logic [31:0] cnt_r;
    logic [1:0] slot_r;
    logic [15:0] rem_r;
    logic [15:0] count_r;
    logic [15:0] per_r;
    logic [31:0] pre_r;
    logic [15:0] ms_r;
    logic [5:0] cfg_r [4];
    logic [1:0] cal_l_r [4];
    logic [2:0] long_r;
    logic [1:0] err_r;
    logic [3:0] dash_r;
    logic [3:0] fresh_r;
    logic [3:0] bad_w;
    logic [3:0] cfg_w;
    logic [3:0] pub;
    logic [2:0] long_now;
    logic [47:0] per_cyc, need_cyc;
    logic ext_fall, ext_low, ctrl_wr, trg_cmd;
    logic ext_ev, rem_ev, pend_ev, trig, loc_hit;
    logic busy_run, slot_end, seq_end, slot_go, seq_go, per_bad;
    logic [1:0] new_src;

    // --------------------------------------------------
    // trigger input and events
    // --------------------------------------------------
    // two-flop synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_m_r <= 1'b1;
            ext_s_r <= 1'b1;
            ext_d_r <= 1'b1;
        end else begin
            ext_m_r <= i_ext_trig_n;
            ext_s_r <= ext_m_r;
            ext_d_r <= ext_s_r;
        end
    end

    // bounces are not filtered, each edge counts
    assign ext_fall = ext_d_r & ~ext_s_r;
    assign ext_low = ~ext_s_r;
    assign ctrl_wr = i_wr && (i_addr == A_CTRL);
    assign trg_cmd = i_wr && (i_addr == A_TRIG);
    assign new_src = i_wdata[1:0];
    // each mode listens to its own kind only
    assign ext_ev = ext_fall && (src_r == SRC_EXT);
    assign rem_ev = trg_cmd && (src_r == SRC_REM);
    // old-kind trigger completes a pending switch
    assign pend_ev = pend_r && (ext_ev || rem_ev);
    assign trig = (ext_ev || rem_ev) && !pend_r;
    assign loc_hit = (src_r == SRC_LOCAL) && ext_low && !ctrl_wr;
    assign busy_run = (st_r != ST_IDLE) && (st_r != ST_HOLD);

    // --------------------------------------------------
    // trigger source
    // --------------------------------------------------
    // only a write, a trigger completing a pending switch, or the local low level moves it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            src_r <= SRC_LOCAL;
            pmode_r <= SRC_LOCAL;
            pend_r <= 1'b0;
        end else if (ctrl_wr && new_src != 2'h3) begin
            if (new_src == SRC_LOCAL || src_r == SRC_LOCAL ||
                    new_src == src_r) begin
                src_r <= mts_src_type'(new_src);
                pend_r <= 1'b0;
            end else begin
                // wait for one trigger of the old kind
                pmode_r <= mts_src_type'(new_src);
                pend_r <= 1'b1;
            end
        end else if (pend_ev) begin
            src_r <= pmode_r;
            pend_r <= 1'b0;
        end else if (loc_hit) begin
            src_r <= SRC_EXT;
        end
    end

    // --------------------------------------------------
    // one-deep trigger buffer
    // --------------------------------------------------
    // set wins; extra triggers fall away
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            buf_r <= 1'b0;
        end else if (loc_hit || (trig && busy_run)) begin
            buf_r <= 1'b1;
        end else if ((st_r == ST_HOLD && seq_go) ||
                (ctrl_wr && new_src == 2'h0)) begin
            // a trigger held is stale once local is selected
            buf_r <= 1'b0;
        end
    end

    // --------------------------------------------------
    // sequencer
    // --------------------------------------------------
    always_comb begin
        long_now = 3'h1;
        for (int i = 0; i < 4; i++) begin
            if (seq_len(cfg_r[i][CFG_CAL+:2]) > long_now)
                long_now = seq_len(cfg_r[i][CFG_CAL+:2]);
        end
    end

    assign slot_end = (st_r == ST_SLOT) &&
        (cnt_r == 32'(SLOT_CYC - 1));
    assign seq_end = slot_end && ({1'b0, slot_r} == long_r - 3'h1);
    assign slot_go = ((st_r == ST_LAT) && (cnt_r == 32'(LAT_CYC - 1)))
        || (slot_end && !seq_end);
    // entry into latency: a new sequence begins
    assign seq_go = ((st_r == ST_IDLE) &&
            ((src_r == SRC_LOCAL) ||
             (src_r != SRC_LOCAL && !buf_r && trig))) ||
        ((st_r == ST_GAP) && (ms_r >= per_r)) ||
        ((st_r == ST_HOLD) && (ms_r >= 16'(HOLD_MS)));

    // no input aborts a started sequence
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 32'h0;
            slot_r <= 2'h0;
            rem_r <= 16'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            unique case (st_r)
                ST_IDLE: begin
                    cnt_r <= 32'h0;
                    if (seq_go) begin
                        st_r <= ST_LAT;
                        // local runs one at a time
                        rem_r <= (src_r == SRC_LOCAL) ? 16'h1 : count_r;
                    end else if (src_r != SRC_LOCAL && buf_r) begin
                        st_r <= ST_HOLD;
                    end
                end
                ST_LAT: begin
                    if (slot_go) begin
                        st_r <= ST_SLOT;
                        cnt_r <= 32'h0;
                        slot_r <= 2'h0;
                    end
                end
                ST_SLOT: begin
                    if (slot_end) begin
                        cnt_r <= 32'h0;
                        slot_r <= slot_r + 2'h1;
                        if (seq_end) begin
                            if (rem_r > 16'h1) begin
                                st_r <= ST_GAP;
                                rem_r <= rem_r - 16'h1;
                            end else if (src_r != SRC_LOCAL && buf_r) begin
                                st_r <= ST_HOLD;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    cnt_r <= 32'h0;
                    if (seq_go) st_r <= ST_LAT;
                end
                ST_HOLD: begin
                    cnt_r <= 32'h0;
                    if (seq_go) begin
                        st_r <= ST_LAT;
                        rem_r <= count_r;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // latch settings so a sequence runs on one configuration
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            long_r <= 3'h1;
            for (int i = 0; i < 4; i++) cal_l_r[i] <= CAL_NONE;
        end else if (seq_go) begin
            long_r <= long_now;
            for (int i = 0; i < 4; i++) cal_l_r[i] <= cfg_r[i][CFG_CAL+:2];
        end
    end

    // millisecond timer from the start of sequence or hold
    always_ff @(posedge i_clk) begin
        if (i_rst || (slot_end && seq_end && rem_r <= 16'h1)) begin
            pre_r <= 32'h0;
            ms_r <= 16'h0;
        end else if (seq_go) begin
            // the start cycle counts, so starts sit one period apart
            pre_r <= 32'(MS_CYC > 1);
            ms_r <= 16'h0;
        end else if (pre_r == 32'(MS_CYC - 1)) begin
            pre_r <= 32'h0;
            if (ms_r != 16'hffff) ms_r <= ms_r + 16'h1;
        end else begin
            pre_r <= pre_r + 32'h1;
        end
    end

    // period between starts runs from the latency entry
    // --------------------------------------------------
    // programmable count, period and errors
    // --------------------------------------------------
    assign per_cyc = 48'(per_r) * 48'(MS_CYC);
    assign need_cyc = 48'(LAT_CYC) + 48'(long_now) * 48'(SLOT_CYC);
    assign per_bad = (src_r != SRC_LOCAL) && (per_cyc < need_cyc);

    always_ff @(posedge i_clk) begin
        if (i_rst) count_r <= CNT_DEF;
        else if (i_wr && i_addr == A_COUNT) count_r <= i_wdata[15:0];
    end

    // too short a period falls back to the default
    always_ff @(posedge i_clk) begin
        if (i_rst) per_r <= PER_DEF;
        else if (per_bad) per_r <= PER_DEF;
        else if (i_wr && i_addr == A_PERIOD) per_r <= i_wdata[15:0];
    end

    // write one to clear; a new error wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            err_r <= 2'h0;
        end else begin
            if (i_wr && i_addr == A_ERR) err_r <= err_r & ~i_wdata[1:0];
            if (per_bad) err_r[ERR_PER] <= 1'b1;
            if (|bad_w) err_r[ERR_MODE] <= 1'b1;
        end
    end

    // --------------------------------------------------
    // per-channel configuration and reading control
    // --------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_ch
        assign cfg_w[g] = i_wr && (i_addr == A_CFG0 + 8'(4 * g));
        // legality checked only off local triggering
        assign bad_w[g] = cfg_w[g] && (src_r != SRC_LOCAL) &&
            !cfg_legal(i_wdata[5:0]);
        assign pub[g] = slot_end &&
            ({1'b0, slot_r} == seq_len(cal_l_r[g]) - 3'h1);

        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                cfg_r[g] <= {ATT_ON, SCALE_20V, CAL_NONE};
            end else if (bad_w[g]) begin
                cfg_r[g] <= {ATT_ON, i_wdata[3:0]};
            end else if (cfg_w[g]) begin
                cfg_r[g] <= i_wdata[5:0];
            end
        end

        // off local, dashes until a reading taken under new settings
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                dash_r[g] <= 1'b0;
                fresh_r[g] <= 1'b0;
            end else if (cfg_w[g]) begin
                dash_r[g] <= (src_r != SRC_LOCAL);
                fresh_r[g] <= 1'b0;
            end else if (pub[g] && fresh_r[g]) begin
                dash_r[g] <= 1'b0;
                fresh_r[g] <= 1'b0;
            end else if (seq_go) begin
                fresh_r[g] <= dash_r[g];
            end
        end

        // reading order; padding marked; own publish
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                o_read_kind[2*g+:2] <= RD_INPUT;
                o_pad[g] <= 1'b0;
                o_publish[g] <= 1'b0;
            end else begin
                o_publish[g] <= pub[g] && (!dash_r[g] || fresh_r[g]);
                if (slot_go) begin
                    o_read_kind[2*g+:2] <= slot_kind(cal_l_r[g],
                        (st_r == ST_LAT) ? 2'h0 : slot_r + 2'h1);
                    o_pad[g] <= (st_r != ST_LAT) &&
                        ({1'b0, slot_r} >= seq_len(cal_l_r[g]) - 3'h1);
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) o_read_start <= 1'b0;
        else o_read_start <= slot_go;
    end

    // busy low only when idle or holding
    assign o_busy = (src_r == SRC_LOCAL) || busy_run;
    assign o_dash = dash_r;

    // --------------------------------------------------
    // register read port
    // --------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 32'h0;
        end else begin
            unique case (i_addr)
                A_CTRL: o_rdata <= {27'h0, pmode_r, pend_r, src_r};
                A_COUNT: o_rdata <= {16'h0, count_r};
                A_PERIOD: o_rdata <= {16'h0, per_r};
                A_CFG0: o_rdata <= {26'h0, cfg_r[0]};
                A_CFG0 + 8'h04: o_rdata <= {26'h0, cfg_r[1]};
                A_CFG0 + 8'h08: o_rdata <= {26'h0, cfg_r[2]};
                A_CFG0 + 8'h0c: o_rdata <= {26'h0, cfg_r[3]};
                A_STATUS: o_rdata <= {rem_r, 4'h0, dash_r,
                    3'h0, buf_r, st_r, o_busy};
                A_ERR: o_rdata <= {16'h0,
                    err_r[ERR_MODE] ? BAD_MODE_ERROR_CODE : 8'h0,
                    6'h0, err_r};
                default: o_rdata <= 32'h0;
            endcase
        end
    end

    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_busy_local: assert property (
        src_r == SRC_LOCAL |-> o_busy)
        else $error("busy low in local mode");

    a_hold_low_time: assert property (
        (st_r == ST_HOLD) ##1 (st_r == ST_LAT)
        |-> $past(ms_r) >= 16'(HOLD_MS) && o_busy)
        else $error("buffered restart too early");

    a_latency_align: assert property (
        st_r == ST_LAT && cnt_r == 32'(LAT_CYC - 1)
        |=> st_r == ST_SLOT && o_read_start && o_read_kind == 8'h0)
        else $error("first aligned input reading missing");

    a_no_abort: assert property (
        st_r == ST_SLOT && !slot_end |=> st_r == ST_SLOT)
        else $error("sequence left early");

    a_publish_slot: assert property (
        |o_publish |-> $past(st_r == ST_SLOT))
        else $error("publish outside a sequence");

    a_period_restore: assert property (
        per_bad |=> per_r == PER_DEF && err_r[ERR_PER])
        else $error("short period not restored");

    a_mode_force: assert property (
        bad_w[0] |=> cfg_r[0][CFG_ATT+:2] == ATT_ON && err_r[ERR_MODE])
        else $error("illegal mode not forced");

    a_local_switch: assert property (
        loc_hit |=> src_r == SRC_EXT && buf_r)
        else $error("local low not taken as external");

    a_pend_switch: assert property (
        pend_ev && !ctrl_wr |=> src_r == $past(pmode_r) && !pend_r)
        else $error("pending switch not completed");

    a_buf_keep: assert property (
        buf_r && busy_run |=> buf_r)
        else $error("buffered trigger lost");
endmodule

/* File: tb/mts_trig_src.sv */
// partner model: external trigger source
`timescale 1ns/1ps
module mts_trig_src (
    // clock
    input wire logic i_clk,
    // trigger pin
    output logic o_trig_n
);
    initial o_trig_n = 1'b1;
    // clean debounced edges
    // one falling edge per call, no bounce, so only commanded triggers count
    task automatic pulse(input int low_cyc);
        @(posedge i_clk);
        o_trig_n <= 1'b0;
        repeat (low_cyc) @(posedge i_clk);
        o_trig_n <= 1'b1;
    endtask
endmodule

/* File: tb/tb_multichannel_trigger_sequencer.sv */
// self-checking bench of the trigger sequencer
`timescale 1ns/1ps
module tb_multichannel_trigger_sequencer;
    import mts_pkg::*;
    // short counts keep the run small
    localparam int MSC = 20;
    localparam int SLC = 4;
    localparam int PER_T = 10;
    logic i_clk, i_rst, i_wr, i_rd, trig_n, o_busy, o_read_start;
    logic [7:0] i_addr, o_read_kind;
    logic [31:0] i_wdata, o_rdata, v;
    logic [3:0] o_pad, o_publish, o_dash;
    logic [1:0] cal [4];
    int miscompares, check_count, seed, n, cnt;
    mts_sequencer #(.MS_CYC(MSC), .SLOT_CYC(SLC)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_trig_n(trig_n),
        .o_busy(o_busy), .o_read_start(o_read_start),
        .o_read_kind(o_read_kind), .o_pad(o_pad), .o_publish(o_publish),
        .o_dash(o_dash));
    mts_trig_src src (.i_clk(i_clk), .o_trig_n(trig_n));
    // --------------------------------------------------
    // helpers
    // --------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // n returns the cycles waited, used for hold times
    task automatic wait_busy(input logic b, input int lim);
        #1 n = 0;
        while (o_busy !== b) begin
            @(posedge i_clk);
            #1 n++;
            if (n > lim) begin
                check(1'b0, "busy wait ran out");
                end_of_test();
            end
        end
    endtask
    task automatic quiet(input int k);
        repeat (k) begin
            @(posedge i_clk);
            #1 check(o_busy === 1'b0, "busy rose");
        end
    endtask
    function automatic logic [1:0] kexp(input logic [1:0] c, input int s);
        if (c == CAL_GND && s == 1) return RD_GROUND;
        if (c == CAL_REFERENCE_THEN_GROUND && s == 1) return RD_REF;
        if (c == CAL_REFERENCE_THEN_GROUND && s == 2) return RD_GROUND;
        if (c == CAL_REFERENCE_LATE_GROUND && s == 1) return RD_REF;
        if (c == CAL_REFERENCE_LATE_GROUND && s == 3) return RD_GROUND;
        return RD_INPUT;
    endfunction
    // k slots expected; lat < 0 skips the latency figure
    task automatic slots(input int k, input int lat);
        int len, w, gap;
        len = 1;
        gap = 0;
        for (int c = 0; c < 4; c++) begin
            if (int'(cal[c]) + 1 > len) len = int'(cal[c]) + 1;
        end
        for (int s = 0; s < k; s++) begin
            w = 0;
            while (o_read_start !== 1'b1) begin
                @(posedge i_clk);
                #1 w++;
                gap++;
                check(o_busy === 1'b1, "busy dropped in run");
                if (w > 30000) begin
                    check(1'b0, "slot wait ran out");
                    end_of_test();
                end
            end
            if (s == 0 && lat >= 0) check(w == lat, "latency");
            if (s % len == 0 && s > 0)
                check(gap == PER_T * MSC, "start spacing");
            if (s % len == 0) gap = 0;
            for (int c = 0; c < 4; c++) begin
                check(o_read_kind[2*c+:2] === kexp(cal[c], s % len), "kind");
                check(o_pad[c] === (s % len >= cal[c] + 1), "pad");
                check(o_publish[c] === (s % len == cal[c] + 1), "pub");
            end
            @(posedge i_clk);
            #1 gap++;
        end
    endtask
    // --------------------------------------------------
    // stimulus
    // --------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        seed = 32'h3e30;
        miscompares = 0;
        check_count = 0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        for (int c = 0; c < 4; c++) cal[c] = CAL_NONE;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        #1 check(o_busy === 1'b1, "busy low in local");
        rd(A_COUNT);
        check(v === 32'h1, "count default");
        rd(A_PERIOD);
        check(v[15:0] === PER_DEF, "period default");
        rd(A_CTRL);
        check(v[1:0] === SRC_LOCAL, "not local");
        // low level in local: switch, local run ends, then held trigger
        fork
            src.pulse(50);
        join_none
        wait_busy(1'b0, 2000);
        wait_busy(1'b1, 2000);
        check(n >= 10 * MSC, "hold short");
        slots(1, -1);
        rd(A_CTRL);
        check(v[1:0] === SRC_EXT, "not external");
        // every calibration mode on its own channel
        for (int c = 0; c < 4; c++) begin
            cal[c] = 2'(c);
            wr(A_CFG0 + 8'(4 * c), 32'h10 | c);
        end
        #1 check(o_dash === 4'hf, "no dashes");
        cnt = 2 + ($unsigned($random(seed)) % 2);
        wr(A_COUNT, cnt);
        wr(A_PERIOD, PER_T);
        fork
            src.pulse(3 + ($unsigned($random(seed)) % 5));
        join_none
        wait_busy(1'b1, 100);
        slots(4 * cnt, LAT_CYC);
        wait_busy(1'b0, 1000);
        check(o_dash === 4'h0, "dashes kept");
        // three triggers: the first starts a run, the second is held while busy, the third is lost
        fork
            repeat (3) begin
                src.pulse(3);
                repeat (20) @(posedge i_clk);
            end
        join_none
        wait_busy(1'b1, 100);
        slots(4 * cnt, LAT_CYC);
        wait_busy(1'b0, 1000);
        wait_busy(1'b1, 2000);
        check(n >= 10 * MSC, "hold short");
        slots(4 * cnt, -1);
        wait_busy(1'b0, 1000);
        quiet(400);
        rd(A_CTRL);
        check(v[1:0] === SRC_EXT, "left external");
        // through local to remote; pin edges ignored there
        wr(A_CTRL, SRC_LOCAL);
        wr(A_CTRL, SRC_REM);
        rd(A_CTRL);
        check(v[1:0] === SRC_REM, "not remote");
        wait_busy(1'b0, 2000);
        fork
            src.pulse(3);
        join_none
        quiet(300);
        wr(A_TRIG, $random(seed));
        wait_busy(1'b1, 20);
        slots(4 * cnt, -1);
        wait_busy(1'b0, 1000);
        // direct switch back waits for one remote trigger, which runs nothing
        wr(A_CTRL, SRC_EXT);
        rd(A_CTRL);
        check(v[4:0] === {SRC_EXT, 1'b1, SRC_REM}, "no pending");
        wr(A_TRIG, 32'h0);
        quiet(20);
        rd(A_CTRL);
        check(v[2:0] === {1'b0, SRC_EXT}, "switch not done");
        // too short period and illegal modes
        wr(A_PERIOD, 32'h1);
        rd(A_ERR);
        check(v[ERR_PER] === 1'b1, "no period error");
        rd(A_PERIOD);
        check(v[15:0] === PER_DEF, "period kept");
        wr(A_CFG0, 32'h06);
        rd(A_ERR);
        check(v[ERR_MODE] === 1'b1, "no mode error");
        check(v[15:8] === BAD_MODE_ERROR_CODE, "code");
        rd(A_CFG0);
        check(v[5:0] === 6'h16, "attenuator not forced");
        wr(A_CFG0, 32'h05);
        rd(A_CFG0);
        check(v[5:0] === 6'h05, "legal mode altered");
        rd(8'h40);
        check(v === 32'h0, "unmapped read");
        end_of_test();
    end
endmodule
